// ==== common/srts_pkg.sv ====
package srts_pkg;

    // ********************************
    // register offsets
    // ********************************
    localparam logic [11:0] SRTS_OFS_CLKDIV = 12'h10b;
    localparam logic [11:0] SRTS_OFS_CTRL   = 12'h120;
    localparam logic [11:0] SRTS_OFS_IGNORE = 12'h121;
    localparam logic [11:0] SRTS_OFS_WIN    = 12'h122;
    localparam logic [11:0] SRTS_OFS_TSDLY  = 12'h123;
    localparam logic [11:0] SRTS_OFS_STATUS = 12'h128;
    localparam logic [11:0] SRTS_OFS_SYNC   = 12'h1ff;
    localparam logic [11:0] SRTS_OFS_FN01   = 12'h559;
    localparam logic [11:0] SRTS_OFS_FN2    = 12'h55a;
    localparam logic [11:0] SRTS_OFS_CS     = 12'h58f;

    // ********************************
    // field positions
    // ********************************
    localparam int SRTS_B_TSEL  = 4;
    localparam int SRTS_B_ESEL  = 3;
    localparam int SRTS_B_MODE  = 1;
    localparam int SRTS_B_WNEG  = 2;
    localparam int SRTS_B_FN1   = 4;
    localparam int SRTS_B_CS    = 6;
    localparam int SRTS_B_HOLD  = 4;

    // ********************************
    // encodings and reset values
    // ********************************
    localparam logic [1:0] SRTS_MODE_OFF  = 2'h0;
    localparam logic [1:0] SRTS_MODE_CONT = 2'h1;
    localparam logic [1:0] SRTS_MODE_NSHT = 2'h2;
    localparam logic [2:0] SRTS_FN_SYSREF = 3'h5;
    localparam logic       SRTS_SYNC_RST  = 1'h0;
    localparam logic [4:0] SRTS_IGN_MAX   = 5'h10;
    localparam logic [4:0] SRTS_LMFC_LEN  = 5'h1f;
    localparam logic [3:0] SRTS_STAT_SAT  = 4'hf;

    typedef enum logic [1:0] {
        SRTS_IDLE,
        SRTS_IGNORE,
        SRTS_WAIT,
        SRTS_CONT
    } srts_fsm_t;

    typedef struct packed {
        logic       tsel;
        logic       esel;
        logic [1:0] mode;
        logic [4:0] ign;
        logic [3:0] win;
        logic [7:0] tsdly;
        logic       sync_ts;
        logic [1:0] cs;
        logic [2:0] fn0;
        logic [2:0] fn1;
        logic [2:0] fn2;
        logic [2:0] cdiv;
        logic [7:0] status;
    } srts_regs_t;

    typedef struct packed {
        logic       wr_en;
        logic       rd_en;
        logic [11:0] addr;
        logic [7:0] wdata;
    } srts_req_t;

endpackage : srts_pkg

// ==== rtl/srts_capture.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - sync mode 1 keeps clocks running and marks the coinciding sample in control bits.
// - timestamps only when mode field is continuous (1) or N-shot (2).
// - timestamps need control-bit count 1, 2 or 3.
// - per control bit a 3-bit selector; value 5 carries the timestamp.
// - control bits are enabled from bit 2 downward.
// - programmable delay shifts which sample gets the mark; latency identical per channel.
// - no timestamping while decimation is in use.
// - writing mode field arms capture: 1 continuous, 2 single or N-shot.
// - single/N-shot mode field self clears after the qualifying transition.
// - normal mode capture resynchronizes divider, DDCs, monitor and link.
// - transition select: 0 low-to-high, 1 high-to-low.
// - edge select: 0 rising capture, 1 falling capture.
// - N-shot mode ignores a programmable count of events, up to 16.
// - continuous mode resyncs when SYSREF misses the LMFC-aligned edge.
// - inside the skew window dividers stay undisturbed; outside triggers realignment.
// - 2-bit negative window before phase 0, 2-bit positive after.
// - read-only status: hold in bits 7:4, setup in bits 3:0.
// - setup detector looks before the edge, hold detector after it.
// - status codes: low setup or low hold hint at margin errors.
// - sync mode bit resets to 0, normal synchronization.
module srts_capture (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // register access
    input  wire srts_pkg::srts_req_t reg_req,
    output logic      [7:0]       reg_rdata,
    // reference pin and mode strap
    input  wire logic             sysref_pin,
    input  wire logic             decim_en,
    // to sample path and link
    output logic                  sample_en,
    output logic                  resync,
    output logic      [2:0]       ctrl_bits
);
    import srts_pkg::*;

    // ********************************
    // state
    // ********************************
    typedef struct packed {
        srts_regs_t r;
        logic       s1;
        logic       s2;
        logic       s3;
        logic       filt;
        logic       filt_d;
        logic       prev;
        logic [2:0] div_cnt;
        logic       sen;
        logic [4:0] lmfc;
        srts_fsm_t  fsm;
        logic [4:0] ign_cnt;
        logic       pend;
        logic [7:0] dly_cnt;
        logic       dly_act;
        logic [3:0] stab;
        logic [3:0] hcnt;
        logic       hrun;
        logic       resync;
        logic [2:0] ctrl;
        logic [7:0] rdata;
    } srts_st_t;

    srts_st_t st_q;
    srts_st_t st_d;

    function automatic logic [2:0] div_max(input logic [2:0] c);
        case (c)
            3'h1:    div_max = 3'h1;
            3'h2:    div_max = 3'h3;
            3'h3:    div_max = 3'h7;
            default: div_max = 3'h0;
        endcase
    endfunction : div_max

    function automatic logic [2:0] cs_mask(input logic [1:0] cs);
        case (cs)
            2'h1:    cs_mask = 3'h4;
            2'h2:    cs_mask = 3'h6;
            2'h3:    cs_mask = 3'h7;
            default: cs_mask = 3'h0;
        endcase
    endfunction : cs_mask

    function automatic logic [2:0] ts_bits(input srts_regs_t r);
        ts_bits = cs_mask(r.cs) & {r.fn2 == SRTS_FN_SYSREF,
                                   r.fn1 == SRTS_FN_SYSREF,
                                   r.fn0 == SRTS_FN_SYSREF};
    endfunction : ts_bits

    // ********************************
    // derived terms
    // ********************************
    logic       edge_lvl;
    logic       edge_prv;
    logic       trans;
    logic       ts_ok;
    logic       in_win;
    logic       act;
    logic [1:0] wneg;
    logic [1:0] wpos;

    // falling capture: one clock only, so it shifts the take by one cycle
    assign edge_lvl = st_q.r.esel ? st_q.filt_d : st_q.filt;
    assign edge_prv = st_q.prev;
    assign trans = (edge_lvl != edge_prv)
                 && (edge_lvl == ~st_q.r.tsel);
    assign ts_ok = st_q.r.sync_ts && !decim_en
                 && (st_q.r.mode == SRTS_MODE_CONT
                     || st_q.r.mode == SRTS_MODE_NSHT)
                 && (st_q.r.cs != 2'h0)
                 && (ts_bits(st_q.r) != 3'h0);
    assign wneg = st_q.r.win[SRTS_B_WNEG +: 2];
    assign wpos = st_q.r.win[1:0];
    // phase 0 is lmfc==0; negative skew lands at the end of the cycle
    assign in_win = (st_q.lmfc <= {3'h0, wpos})
                  || ((wneg != 2'h0)
                      && (st_q.lmfc >= SRTS_LMFC_LEN + 5'h1 - {3'h0, wneg}));
    assign act = st_q.sen && st_q.pend
               && (st_q.fsm == SRTS_WAIT || st_q.fsm == SRTS_CONT);

    // ********************************
    // next state
    // ********************************
    always_comb begin
        st_d = st_q;
        st_d.resync = 1'b0;
        st_d.ctrl = 3'h0;

        // pin sync: a change counts when stages two and three agree
        st_d.s1 = sysref_pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        if (st_q.s2 == st_q.s3) begin
            st_d.filt = st_q.s3;
        end
        st_d.filt_d = st_q.filt;
        st_d.prev = edge_lvl;

        // sample divider
        st_d.sen = 1'b0;
        if (st_q.div_cnt >= div_max(st_q.r.cdiv)) begin
            st_d.div_cnt = 3'h0;
            st_d.sen = 1'b1;
        end else begin
            st_d.div_cnt = st_q.div_cnt + 3'h1;
        end
        if (st_q.sen) begin
            st_d.lmfc = (st_q.lmfc == SRTS_LMFC_LEN) ? 5'h0 : st_q.lmfc + 5'h1;
        end

        // setup and hold monitor
        if (trans) begin
            st_d.r.status[3:0] = st_q.stab;
            st_d.hcnt = 4'h0;
            st_d.hrun = 1'b1;
            st_d.stab = 4'h0;
        end else begin
            if (edge_lvl == edge_prv && st_q.stab != SRTS_STAT_SAT) begin
                st_d.stab = st_q.stab + 4'h1;
            end
            if (st_q.hrun) begin
                if (edge_lvl == edge_prv && st_q.hcnt != SRTS_STAT_SAT) begin
                    st_d.hcnt = st_q.hcnt + 4'h1;
                end else begin
                    st_d.hrun = 1'b0;
                    st_d.r.status[SRTS_B_HOLD +: 4] = st_q.hcnt;
                end
            end
        end

        // events wait for the next sample slot
        if (trans && st_q.fsm != SRTS_IDLE) begin
            st_d.pend = 1'b1;
        end else if (st_q.sen) begin
            st_d.pend = 1'b0;
        end

        // capture state machine
        case (st_q.fsm)
            SRTS_IDLE: begin
            end
            SRTS_IGNORE: begin
                if (st_q.sen && st_q.pend) begin
                    st_d.ign_cnt = st_q.ign_cnt - 5'h1;
                    if (st_q.ign_cnt == 5'h1) begin
                        st_d.fsm = SRTS_WAIT;
                    end
                end
            end
            SRTS_WAIT: begin
                if (act) begin
                    st_d.r.mode = SRTS_MODE_OFF;
                    st_d.fsm = SRTS_IDLE;
                end
            end
            SRTS_CONT: begin
            end
            default: begin
                st_d.fsm = SRTS_IDLE;
            end
        endcase

        // act on the qualifying event
        if (act) begin
            if (ts_ok) begin
                st_d.dly_cnt = st_q.r.tsdly;
                st_d.dly_act = 1'b1;
            end else if (!st_q.r.sync_ts
                         && (st_q.fsm == SRTS_WAIT || !in_win)) begin
                st_d.resync = 1'b1;
                // captured sample is phase 0, so the next one is phase 1
                st_d.lmfc = 5'h1;
                st_d.div_cnt = 3'h0;
            end
        end

        // timestamp mark after programmed delay, clocks left alone
        if (st_q.dly_act && st_q.sen) begin
            if (st_q.dly_cnt == 8'h0) begin
                st_d.ctrl = ts_bits(st_q.r);
                st_d.dly_act = 1'b0;
            end else begin
                st_d.dly_cnt = st_q.dly_cnt - 8'h1;
            end
        end

        // register writes win over the self clear
        if (reg_req.wr_en) begin
            case (reg_req.addr)
                SRTS_OFS_CLKDIV: st_d.r.cdiv = reg_req.wdata[2:0];
                SRTS_OFS_CTRL: begin
                    st_d.r.tsel = reg_req.wdata[SRTS_B_TSEL];
                    st_d.r.esel = reg_req.wdata[SRTS_B_ESEL];
                    st_d.r.mode = reg_req.wdata[SRTS_B_MODE +: 2];
                    st_d.pend = 1'b0;
                    st_d.ign_cnt = st_q.r.ign;
                    case (reg_req.wdata[SRTS_B_MODE +: 2])
                        SRTS_MODE_CONT: st_d.fsm = SRTS_CONT;
                        SRTS_MODE_NSHT: st_d.fsm = (st_q.r.ign == 5'h0)
                                                   ? SRTS_WAIT : SRTS_IGNORE;
                        default:        st_d.fsm = SRTS_IDLE;
                    endcase
                end
                SRTS_OFS_IGNORE: begin
                    st_d.r.ign = (reg_req.wdata[4:0] > SRTS_IGN_MAX)
                               ? SRTS_IGN_MAX : reg_req.wdata[4:0];
                end
                SRTS_OFS_WIN:   st_d.r.win = reg_req.wdata[3:0];
                SRTS_OFS_TSDLY: st_d.r.tsdly = reg_req.wdata;
                SRTS_OFS_SYNC:  st_d.r.sync_ts = reg_req.wdata[0];
                SRTS_OFS_FN01: begin
                    st_d.r.fn0 = reg_req.wdata[2:0];
                    st_d.r.fn1 = reg_req.wdata[SRTS_B_FN1 +: 3];
                end
                SRTS_OFS_FN2: st_d.r.fn2 = reg_req.wdata[2:0];
                SRTS_OFS_CS:  st_d.r.cs = reg_req.wdata[SRTS_B_CS +: 2];
                default: begin
                end
            endcase
        end

        // read data, unmapped reads as zero
        st_d.rdata = 8'h0;
        if (reg_req.rd_en) begin
            case (reg_req.addr)
                SRTS_OFS_CLKDIV: st_d.rdata = {5'h0, st_q.r.cdiv};
                SRTS_OFS_CTRL: begin
                    st_d.rdata = {3'h0, st_q.r.tsel, st_q.r.esel,
                                  st_q.r.mode, 1'b0};
                end
                SRTS_OFS_IGNORE: st_d.rdata = {3'h0, st_q.r.ign};
                SRTS_OFS_WIN:    st_d.rdata = {4'h0, st_q.r.win};
                SRTS_OFS_TSDLY:  st_d.rdata = st_q.r.tsdly;
                SRTS_OFS_STATUS: st_d.rdata = st_q.r.status;
                SRTS_OFS_SYNC:   st_d.rdata = {7'h0, st_q.r.sync_ts};
                SRTS_OFS_FN01: begin
                    st_d.rdata = {1'b0, st_q.r.fn1, 1'b0, st_q.r.fn0};
                end
                SRTS_OFS_FN2:    st_d.rdata = {5'h0, st_q.r.fn2};
                SRTS_OFS_CS:     st_d.rdata = {st_q.r.cs, 6'h0};
                default:         st_d.rdata = 8'h0;
            endcase
        end
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= '0;
            st_q.r.sync_ts <= SRTS_SYNC_RST;
            st_q.fsm <= SRTS_IDLE;
        end else begin
            st_q <= st_d;
        end
    end

    assign sample_en = st_q.sen;
    assign resync = st_q.resync;
    assign ctrl_bits = st_q.ctrl;
    assign reg_rdata = st_q.rdata;

    // ********************************
    // checks
    // ********************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_TS_NO_RESYNC: assert property (st_q.r.sync_ts |-> !resync)
        else $error("resync while in timestamp mode");
    AST_MARK_NEEDS_MODE: assert property (
        (ctrl_bits != 3'h0) |-> $past(st_q.r.sync_ts))
        else $error("mark outside timestamp mode");
    AST_MARK_CS: assert property (
        (ctrl_bits != 3'h0) |-> ((ctrl_bits & ~cs_mask(st_q.r.cs)) == 3'h0))
        else $error("mark on a disabled control bit");
    AST_MARK_DECIM: assert property (
        act && decim_en |=> !st_q.dly_act || $past(st_q.dly_act))
        else $error("timestamp started under decimation");
    AST_SELF_CLEAR: assert property (
        (st_q.fsm == SRTS_WAIT && act && !reg_req.wr_en)
        |=> st_q.r.mode == SRTS_MODE_OFF && st_q.fsm == SRTS_IDLE)
        else $error("mode field not cleared after capture");
    AST_ARM_CONT: assert property (
        reg_req.wr_en && reg_req.addr == SRTS_OFS_CTRL
        && reg_req.wdata[2:1] == SRTS_MODE_CONT |=> st_q.fsm == SRTS_CONT)
        else $error("continuous mode not armed");
    AST_WIN_QUIET: assert property (
        act && st_q.fsm == SRTS_CONT && in_win |=> !resync)
        else $error("resync inside skew window");
    AST_RESYNC_OUT: assert property (
        act && st_q.fsm == SRTS_CONT && !in_win && !st_q.r.sync_ts
        |=> resync && st_q.lmfc == 5'h1)
        else $error("no realignment outside window");
    AST_NSHOT_RESYNC: assert property (
        act && st_q.fsm == SRTS_WAIT && !st_q.r.sync_ts |=> resync)
        else $error("normal mode capture without resync");
    AST_IGNORE_HOLD: assert property (
        st_q.fsm == SRTS_IGNORE && !reg_req.wr_en |=> !resync)
        else $error("acted on an ignored event");

    COV_TS_MARK: cover property (ctrl_bits != 3'h0);
    COV_CONT_RESYNC: cover property (st_q.fsm == SRTS_CONT ##1 resync);
    COV_NSHOT_DONE: cover property (st_q.fsm == SRTS_IGNORE ##[1:200] st_q.fsm == SRTS_IDLE);

endmodule : srts_capture

// ==== dv/srts_sysref_src.sv ====
`timescale 1ns/1ps
module srts_sysref_src (
    // device clock
    input  wire logic clk,
    // reference level toward the device
    output logic      sysref
);
    // ****************************
    // stimulus tasks
    // ****************************
    initial sysref = 1'b0;

    // caller sits just after a rising edge; level is held n whole clocks
    task automatic level(input logic v, input int n);
        sysref = v;
        repeat (n) @(posedge clk);
        #2;
    endtask : level

    // width must reach two clocks times the divide ratio
    task automatic pulse(input int w, input int g);
        level(1'b1, w);
        level(1'b0, g);
    endtask : pulse

    // period kept a whole number of 32-sample multiframes
    task automatic train(input int n, input int p, input int w);
        repeat (n) pulse(w, p - w);
    endtask : train
endmodule : srts_sysref_src

// ==== dv/srts_capture_test.sv ====
`timescale 1ns/1ps
module srts_capture_test;
    import srts_pkg::*;
    logic       clk;
    logic       arst_n;
    logic       sysref_pin;
    logic       decim_en;
    logic       sample_en;
    logic       resync;
    logic [7:0] reg_rdata;
    logic [2:0] ctrl_bits;
    logic [2:0] mark_acc;
    srts_req_t  reg_req;
    int         fail_count;
    int         n_tests;
    int         rs_cnt;
    int         se_cnt;
    int         mark_t;
    int         t0;
    int         rs_t;
    int         lat;
    int         l0;
    int         cyc;
    int         ign_tab [3] = '{16, 3, 0};
    logic [7:0] combo [4]   = '{8'h04, 8'h0c, 8'h14, 8'h1c};

    srts_capture dut (
        .clk        (clk),
        .arst_n     (arst_n),
        .reg_req    (reg_req),
        .reg_rdata  (reg_rdata),
        .sysref_pin (sysref_pin),
        .decim_en   (decim_en),
        .sample_en  (sample_en),
        .resync     (resync),
        .ctrl_bits  (ctrl_bits)
    );

    srts_sysref_src src (
        .clk    (clk),
        .sysref (sysref_pin)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ****************************
    // monitors and tasks
    // ****************************
    // registered outputs read at the edge show the cycle just ended
    always @(posedge clk) begin
        cyc = cyc + 1;
        rs_cnt = rs_cnt + int'(resync === 1'b1);
        se_cnt = se_cnt + int'(sample_en === 1'b1);
        if (ctrl_bits !== 3'h0 && mark_t < 0)
            mark_t = cyc;
        if (resync === 1'b1 && rs_t < 0)
            rs_t = cyc;
        mark_acc = mark_acc | ctrl_bits;
    end

    task automatic clr();
        rs_cnt = 0;
        se_cnt = 0;
        mark_acc = 3'h0;
        mark_t = -1;
        rs_t = -1;
        t0 = cyc;
    endtask : clr

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        #2 reg_req = '{1'b1, 1'b0, a, d};
        @(posedge clk);
        #2 reg_req = '0;
    endtask : wr

    task automatic rc(input logic [11:0] a, input logic [7:0] exp);
        @(posedge clk);
        #2 reg_req = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        #2 reg_req = '0;
        check($sformatf("reg %h", a), reg_rdata, exp);
    endtask : rc

    task automatic ts_run(input logic [7:0] cs, input logic [7:0] ctl, input logic dec, input logic [2:0] exp);
        wr(SRTS_OFS_CS, cs);
        wr(SRTS_OFS_CTRL, ctl);
        decim_en = dec;
        clr();
        src.pulse(4, 30);
        lat = mark_t - t0;
        check("mark", {5'h0, mark_acc}, {5'h0, exp});
        check("ts resync", 8'(rs_cnt), 8'h00);
    endtask : ts_run

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("MISMATCH watchdog expected done seen hang");
        test_done();
    end

    // ****************************
    // test sequence
    // ****************************
    initial begin
        reg_req = '0;
        decim_en = 1'b0;
        arst_n = 1'b0;
        cyc = 0;
        fail_count = 0;
        n_tests = 0;
        clr();
        repeat (6) @(posedge clk);
        #2 arst_n = 1'b1;
        rc(SRTS_OFS_SYNC, 8'h00);
        rc(SRTS_OFS_CTRL, 8'h00);
        rc(SRTS_OFS_STATUS, 8'h00);
        rc(12'h7ff, 8'h00);
        wr(SRTS_OFS_WIN, 8'h0f);
        rc(SRTS_OFS_WIN, 8'h0f);
        wr(SRTS_OFS_STATUS, 8'h5a);
        rc(SRTS_OFS_STATUS, 8'h00);
        wr(SRTS_OFS_WIN, 8'h00);
        clr();
        src.pulse(4, 20);
        check("unarmed", 8'(rs_cnt), 8'h00);
        $display("test registers done");
        foreach (ign_tab[i]) begin
            wr(SRTS_OFS_IGNORE, 8'(ign_tab[i]));
            wr(SRTS_OFS_CTRL, 8'h04);
            clr();
            repeat (ign_tab[i]) src.pulse(4, 20);
            check("ignored", 8'(rs_cnt), 8'h00);
            src.pulse(4, 20);
            check("nshot", 8'(rs_cnt), 8'h01);
            rc(SRTS_OFS_CTRL, 8'h00);
        end
        $display("test nshot done");
        foreach (combo[i]) begin
            wr(SRTS_OFS_CTRL, combo[i]);
            clr();
            src.level(1'b1, 20);
            check("on rise", 8'(rs_cnt), {7'h0, ~combo[i][4]});
            src.level(1'b0, 20);
            check("on fall", 8'(rs_cnt), 8'h01);
            // falling capture takes the event one clock later than rising
            if (combo[i][3] == 1'b0)
                l0 = rs_t - t0;
            else
                check("capture lag", 8'(rs_t - t0 - l0), 8'h01);
        end
        // both sides of the last transition were stable long enough to saturate
        rc(SRTS_OFS_STATUS, 8'hff);
        $display("test edges done");
        wr(SRTS_OFS_CLKDIV, 8'h01);
        clr();
        repeat (16) @(posedge clk);
        #2;
        check("div2", 8'(se_cnt), 8'h08);
        wr(SRTS_OFS_CTRL, 8'h04);
        clr();
        src.pulse(4, 30);
        check("div2 capture", 8'(rs_cnt), 8'h01);
        wr(SRTS_OFS_CLKDIV, 8'h00);
        $display("test divider done");
        wr(SRTS_OFS_SYNC, 8'h01);
        wr(SRTS_OFS_FN01, 8'h50);
        ts_run(8'h80, 8'h04, 1'b0, 3'h2);
        l0 = lat;
        wr(SRTS_OFS_TSDLY, 8'h03);
        ts_run(8'h80, 8'h04, 1'b0, 3'h2);
        check("ts delay", 8'(lat - l0), 8'h03);
        wr(SRTS_OFS_TSDLY, 8'h00);
        wr(SRTS_OFS_FN2, 8'h05);
        ts_run(8'h40, 8'h04, 1'b0, 3'h4);
        ts_run(8'h40, 8'h02, 1'b0, 3'h4);
        ts_run(8'h40, 8'h00, 1'b0, 3'h0);
        ts_run(8'h00, 8'h04, 1'b0, 3'h0);
        ts_run(8'h40, 8'h04, 1'b1, 3'h0);
        decim_en = 1'b0;
        $display("test timestamp done");
        wr(SRTS_OFS_SYNC, 8'h00);
        wr(SRTS_OFS_CS, 8'h00);
        wr(SRTS_OFS_WIN, 8'h00);
        wr(SRTS_OFS_CTRL, 8'h02);
        src.train(2, 64, 4);
        clr();
        src.train(3, 64, 4);
        check("aligned", 8'(rs_cnt), 8'h00);
        clr();
        src.level(1'b0, 1);
        src.pulse(4, 57);
        check("late no window", 8'(rs_cnt), 8'h01);
        // write takes two clocks, counted into the next slot
        wr(SRTS_OFS_WIN, 8'h01);
        src.level(1'b0, 2);
        clr();
        src.pulse(4, 59);
        check("late inside", 8'(rs_cnt), 8'h00);
        src.level(1'b0, 2);
        src.pulse(4, 57);
        check("late outside", 8'(rs_cnt), 8'h01);
        wr(SRTS_OFS_WIN, 8'h04);
        clr();
        src.pulse(4, 30);
        check("early inside", 8'(rs_cnt), 8'h00);
        rc(SRTS_OFS_CTRL, 8'h02);
        $display("test continuous done");
        test_done();
    end
endmodule : srts_capture_test
